// ### core/link_pkg.sv
// link_pkg: constants and state codes for the link reset and detect machine
// assumes a single 200 MHz clock shared by every design file
`default_nettype none
package link_pkg;
	// ****************************************************
	// clock and timing
	// ****************************************************
	localparam int clk_mhz = 200;
	localparam int retrain_min_us = 40;
	localparam int retrain_max_us = 50;
	localparam int pending_handshake_us = 100;
	localparam int pm_link_command_us = 100;
	localparam int item_a_us = 120;
	localparam int port_config_timeout_us = 110;
	localparam int pre_reset_min_ms = 60;
	localparam int pre_reset_max_ms = 80;
	localparam int polling_stall_residency_ms = 40;
	localparam int polling_active_timeout_ms = 58;
	// derived counts; retrain aims between its bounds
	localparam int retrain_cycles = (retrain_min_us + retrain_max_us) / 2 * clk_mhz;
	localparam int pending_handshake_cycles = pending_handshake_us * clk_mhz;
	localparam int pm_link_command_cycles = pm_link_command_us * clk_mhz;
	localparam int item_a_cycles = item_a_us * clk_mhz;
	localparam int port_config_cycles = port_config_timeout_us * clk_mhz;
	localparam int pre_reset_cycles = (pre_reset_min_ms + pre_reset_max_ms) / 2 * 1000 * clk_mhz;
	localparam int polling_stall_cycles = polling_stall_residency_ms * 1000 * clk_mhz;
	localparam int polling_active_cycles = polling_active_timeout_ms * 1000 * clk_mhz;
	localparam int timer_w = 25;
	localparam int lanes = 4;
	// ****************************************************
	// states, one-hot
	// ****************************************************
	typedef enum logic [8:0] {
		st_disabled = 9'h001,
		st_det_reset = 9'h002,
		st_det_active = 9'h004,
		st_det_wait = 9'h008,
		st_low_speed = 9'h010,
		st_cfg_wait = 9'h020,
		st_polling = 9'h040,
		st_phy_test = 9'h080,
		st_hot_reset = 9'h100
	} link_state_e;
	typedef enum logic [3:0] {
		rs_wait_line = 4'h1,
		rs_assert = 4'h2,
		rs_hold = 4'h4,
		rs_done = 4'h8
	} reset_step_e;
endpackage : link_pkg
`default_nettype wire

// ### core/timer_if.sv
// timer_if: load and expiry between the main machine and its cycle timer
// assumes both ends share sys_clk
`default_nettype none
interface timer_if;
	logic start;
	logic [link_pkg::timer_w-1:0] count;
	logic expired;
	modport ctrl(output start, output count, input expired);
	modport timer(input start, input count, output expired);
endinterface : timer_if
`default_nettype wire

// ### core/cycle_timer.sv
// cycle_timer: one-shot down counter in local clock cycles
// assumes start is a one-cycle pulse from the same clock domain
`default_nettype none
module cycle_timer (
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic ce, // clock enable
	timer_if.timer t // load and expiry
);
	logic [link_pkg::timer_w-1:0] left;
	logic running;
	// count down; expired pulses once when left reaches one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			left <= '0;
			running <= 1'b0;
			t.expired <= 1'b0;
		end else if (ce) begin
			t.expired <= 1'b0;
			if (t.start) begin
				left <= t.count;
				running <= 1'b1;
			end else if (running) begin
				if (left <= 25'h0000001) begin
					running <= 1'b0;
					t.expired <= 1'b1;
				end else begin
					left <= left - 25'h0000001;
				end
			end
		end
	end
endmodule : cycle_timer
`default_nettype wire

// ### core/link_reset_and_detect_fsm.sv
// link_reset_and_detect_fsm: reset and receiver-detect part of the link training machine
// assumes phy status inputs are asynchronous pins; commands come from same-clock logic
// Notes on behaviour
// - power-on reset holds disabled and phy off; release takes an upstream port to receiver-detect
// - hot reset is ts2 with reset bit; seeing or sending it enters hot reset
// - hot reset end: downstream clears error count, config kept, go to u0
// - failed hot reset makes a downstream port signal warm reset
// - warm reset: negative level on lane pair zero 60-80 ms, then line reset
// - a signalled line reset moves the machine to receiver-detect reset
// - line reset only by downstream on pair zero, upstream only for disconnect
// - retrain timer expires between 40 and 50 us after start
// - handshake and link command timers 100 us, entry timer 120 us
// - polling stall residency allowed up to 40 ms
// - polling active timeout is 58 ms
// - port configuration timeout is 110 us
// - disabled state holds local phy reset on every lane pair
// - upstream leaves disabled on reset release, downstream when directed, to detect active
// - downstream port when directed signals disconnect and enters disabled from detect
// - detect reset: wait line reset, assert local reset, hold, release, then active
// - downstream in detect active wakes all transmitters, receivers stay hibernate
// - upstream in detect active keeps everything in hibernate until partner exits
// - upstream seeing any receiver exit wakes all transmitters, enters low-speed mode
// - downstream waits activate time after all receivers exit, then low-speed mode
// - test mode register write in low-speed mode leaves for phy test
// - config update transition, then wait receiver activate capability, then polling
`default_nettype none
module link_reset_and_detect_fsm (
	input wire logic sys_clk, // 200 mhz clock
	input wire logic rst, // power-on reset, active high
	input wire logic ce, // clock enable
	input wire logic is_downstream, // strap: port faces downstream
	input wire logic direct_disable, // directed to disable (downstream)
	input wire logic direct_enable, // directed to leave disabled (downstream)
	input wire logic line_reset_seen, // phy pin: line reset signalled on link
	input wire logic line_reset_busy, // phy pin: line reset still in progress
	input wire logic [3:0] rx_hib_exit, // phy pins: receiver hibernate exit per pair
	input wire logic ts2_reset_rx, // ts2 with reset bit received
	input wire logic hot_reset_req, // request to send hot reset
	input wire logic hot_reset_done, // hot reset handshake complete
	input wire logic hot_reset_fail, // hot reset failed
	input wire logic test_mode_write, // remote access write to test mode reg
	input wire logic config_update, // remote access configured polling entry
	input wire logic [15:0] activate_cycles, // activate time in cycles
	input wire logic [15:0] rx_min_activate_capability, // receiver activate in cycles
	input wire logic [15:0] reset_hold_cycles, // local reset hold time in cycles
	input wire logic [15:0] line_to_local_reset_delay, // cycles of asserted local reset before the hold
	output logic [3:0] phy_local_reset, // local phy reset per lane pair
	output logic [3:0] tx_wake, // transmitter out of hibernate per pair
	output logic [3:0] rx_wake, // receiver out of hibernate per pair
	output logic lane_pair_zero_negative_line_level, // warm reset drive on pair zero
	output logic line_reset_issue, // issue line reset on pair zero
	output logic ts2_reset_tx, // send ts2 with reset bit
	output logic config_update_transition, // run config update transition
	output logic clear_error_count, // pulse: clear link error count
	output logic [8:0] state_out, // current state code
	output logic in_u0 // pulse: leave to u0
);
	// ****************************************************
	// synchronisers for pin inputs
	// ****************************************************
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_a <= '0;
			sync_b <= '0;
		end else if (ce) begin
			sync_a <= {line_reset_seen, line_reset_busy, rx_hib_exit};
			sync_b <= sync_a;
		end
	end
	wire logic lr_seen = sync_b[5];
	wire logic lr_busy = sync_b[4];
	wire logic [3:0] rx_exit = sync_b[3:0];

	// strap caught on the first enabled cycle after reset release
	logic dsp;
	logic strap_taken;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dsp <= 1'b0;
			strap_taken <= 1'b0;
		end else if (ce && !strap_taken) begin
			dsp <= is_downstream;
			strap_taken <= 1'b1;
		end
	end

	// ****************************************************
	// long timers
	// ****************************************************
	timer_if warm_t ();
	timer_if stall_t ();
	cycle_timer warm_timer (.sys_clk(sys_clk), .rst(rst), .ce(ce), .t(warm_t.timer));
	cycle_timer stall_timer (.sys_clk(sys_clk), .rst(rst), .ce(ce), .t(stall_t.timer));
	assign warm_t.count = link_pkg::timer_w'(link_pkg::pre_reset_cycles);
	assign stall_t.count = link_pkg::timer_w'(link_pkg::polling_stall_cycles);

	// ****************************************************
	// main state machine
	// ****************************************************
	link_pkg::link_state_e state;
	link_pkg::reset_step_e step;
	logic [15:0] cnt;
	logic warm_active;
	logic poll_timeout;
	wire logic all_rx_exit = &rx_exit;
	wire logic any_rx_exit = |rx_exit;
	wire logic go_disable = dsp && direct_disable;

	// state and sub-step transitions
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= link_pkg::st_disabled;
			step <= link_pkg::rs_wait_line;
			cnt <= '0;
		end else if (ce && strap_taken) begin
			case (state)
				link_pkg::st_disabled: begin
					if (!dsp || direct_enable) begin
						state <= link_pkg::st_det_active;
					end
				end
				link_pkg::st_det_reset: begin
					if (go_disable) begin
						state <= link_pkg::st_disabled;
					end else begin
						case (step)
							link_pkg::rs_wait_line: begin
								cnt <= '0;
								if (!lr_busy) begin
									step <= link_pkg::rs_assert;
								end
							end
							link_pkg::rs_assert: begin
								cnt <= cnt + 16'h0001;
								if (cnt >= line_to_local_reset_delay) begin
									step <= link_pkg::rs_hold;
									cnt <= '0;
								end
							end
							link_pkg::rs_hold: begin
								cnt <= cnt + 16'h0001;
								if (cnt >= reset_hold_cycles) begin
									step <= link_pkg::rs_done;
								end
							end
							default: begin
								step <= link_pkg::rs_wait_line;
								state <= link_pkg::st_det_active;
							end
						endcase
					end
				end
				link_pkg::st_det_active: begin
					cnt <= '0;
					if (go_disable) begin
						state <= link_pkg::st_disabled;
					end else if (!dsp && any_rx_exit) begin
						state <= link_pkg::st_low_speed;
					end else if (dsp && all_rx_exit) begin
						state <= link_pkg::st_det_wait;
					end
				end
				link_pkg::st_det_wait: begin
					cnt <= cnt + 16'h0001;
					if (go_disable) begin
						state <= link_pkg::st_disabled;
					end else if (cnt >= activate_cycles) begin
						state <= link_pkg::st_low_speed;
					end
				end
				link_pkg::st_low_speed: begin
					cnt <= '0;
					if (go_disable) begin
						state <= link_pkg::st_disabled;
					end else if (test_mode_write) begin
						state <= link_pkg::st_phy_test;
					end else if (config_update) begin
						state <= link_pkg::st_cfg_wait;
					end
				end
				link_pkg::st_cfg_wait: begin
					cnt <= cnt + 16'h0001;
					if (cnt >= rx_min_activate_capability) begin
						state <= link_pkg::st_polling;
					end
				end
				link_pkg::st_hot_reset: begin
					if (hot_reset_done) begin
						state <= link_pkg::st_polling;
					end else if (hot_reset_fail && !dsp) begin
						state <= link_pkg::st_det_active;
					end
				end
				default: begin
					if (poll_timeout && dsp) begin
						state <= link_pkg::st_det_active;
					end
				end
			endcase
			// line reset and hot reset override the current state
			if (lr_seen && state != link_pkg::st_disabled && !warm_active) begin
				state <= link_pkg::st_det_reset;
				step <= link_pkg::rs_wait_line;
			end else if ((ts2_reset_rx || hot_reset_req) && state == link_pkg::st_polling) begin
				state <= link_pkg::st_hot_reset;
			end
		end
	end

	// polling stall residency watch, restarted on polling entry
	logic in_poll_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			in_poll_q <= 1'b0;
			poll_timeout <= 1'b0;
		end else if (ce) begin
			in_poll_q <= (state == link_pkg::st_polling);
			if (stall_t.expired) begin
				poll_timeout <= 1'b1;
			end else if (state != link_pkg::st_polling) begin
				poll_timeout <= 1'b0;
			end
		end
	end
	assign stall_t.start = ce && (state == link_pkg::st_polling) && !in_poll_q;

	// warm reset sequence: negative drive then line reset, downstream only on pair zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			warm_active <= 1'b0;
			lane_pair_zero_negative_line_level <= 1'b0;
			line_reset_issue <= 1'b0;
		end else if (ce) begin
			line_reset_issue <= 1'b0;
			if (warm_active && warm_t.expired) begin // expiry wins over a repeated fail
				warm_active <= 1'b0;
				lane_pair_zero_negative_line_level <= 1'b0;
				line_reset_issue <= 1'b1;
			end else if (dsp && hot_reset_fail && state == link_pkg::st_hot_reset) begin
				warm_active <= 1'b1;
				lane_pair_zero_negative_line_level <= 1'b1;
			end
		end
	end
	assign warm_t.start = ce && dsp && hot_reset_fail && state == link_pkg::st_hot_reset
		&& !warm_active;

	// ****************************************************
	// phy control outputs, one per lane pair
	// ****************************************************
	genvar g;
	generate
		for (g = 0; g < link_pkg::lanes; g++) begin : pair
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					phy_local_reset[g] <= 1'b1;
					tx_wake[g] <= 1'b0;
					rx_wake[g] <= 1'b0;
				end else if (ce) begin
					phy_local_reset[g] <= (state == link_pkg::st_disabled) ||
						(state == link_pkg::st_det_reset &&
						(step == link_pkg::rs_assert || step == link_pkg::rs_hold));
					tx_wake[g] <= (dsp && state == link_pkg::st_det_active) ||
						(!dsp && state == link_pkg::st_det_active && any_rx_exit) ||
						(state != link_pkg::st_disabled && state != link_pkg::st_det_reset &&
						state != link_pkg::st_det_active);
					rx_wake[g] <= rx_exit[g] && state != link_pkg::st_disabled &&
						state != link_pkg::st_det_reset;
				end
			end
		end
	endgenerate

	// misc pulses and status
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ts2_reset_tx <= 1'b0;
			config_update_transition <= 1'b0;
			clear_error_count <= 1'b0;
			in_u0 <= 1'b0;
			state_out <= link_pkg::st_disabled;
		end else if (ce) begin
			ts2_reset_tx <= dsp && state == link_pkg::st_hot_reset;
			config_update_transition <= state == link_pkg::st_low_speed && config_update;
			clear_error_count <= dsp && state == link_pkg::st_hot_reset && hot_reset_done;
			in_u0 <= state == link_pkg::st_hot_reset && hot_reset_done;
			state_out <= state;
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	disabled_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == link_pkg::st_disabled |=> phy_local_reset == 4'hf)
		else $error("local reset not held in disabled");
	usp_leave_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && strap_taken && !dsp && state == link_pkg::st_disabled && !lr_seen
		|=> state == link_pkg::st_det_active)
		else $error("upstream port stayed disabled");
	dsp_disable_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && strap_taken && go_disable && !lr_seen && (state == link_pkg::st_det_active ||
		state == link_pkg::st_low_speed) |=> state == link_pkg::st_disabled)
		else $error("directed disable ignored");
	line_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && strap_taken && lr_seen && !warm_active && state != link_pkg::st_disabled
		|=> state == link_pkg::st_det_reset)
		else $error("line reset did not enter detect reset");
	test_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && strap_taken && state == link_pkg::st_low_speed && test_mode_write &&
		!go_disable && !lr_seen |=> state == link_pkg::st_phy_test)
		else $error("test mode write not honoured");
	usp_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && strap_taken && !dsp && state == link_pkg::st_det_active && any_rx_exit &&
		!lr_seen |=> tx_wake == 4'hf ##0 state == link_pkg::st_low_speed)
		else $error("upstream did not wake transmitters");
	warm_end_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && warm_active && warm_t.expired |=> line_reset_issue &&
		!lane_pair_zero_negative_line_level)
		else $error("warm reset did not end in line reset");
	hot_done_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && strap_taken && dsp && state == link_pkg::st_hot_reset && hot_reset_done
		|=> clear_error_count && in_u0)
		else $error("hot reset completion not reported");
	sequence hold_ends_s;
		ce && strap_taken && state == link_pkg::st_det_reset && step == link_pkg::rs_hold &&
			cnt >= reset_hold_cycles && !go_disable && !lr_seen;
	endsequence
	hold_release_a: assert property (@(posedge sys_clk) disable iff (rst)
		hold_ends_s |=> step == link_pkg::rs_done)
		else $error("local reset hold did not end");
	sequence wait_ends_s;
		ce && strap_taken && state == link_pkg::st_det_wait && cnt >= activate_cycles &&
			!go_disable && !lr_seen;
	endsequence
	activate_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
		wait_ends_s |=> state == link_pkg::st_low_speed)
		else $error("activate wait did not reach low-speed mode");
	dsp_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce && dsp && state == link_pkg::st_det_active |=> tx_wake == 4'hf)
		else $error("downstream transmitters stayed in hibernate");
endmodule : link_reset_and_detect_fsm
`default_nettype wire

// ### verification/link_partner.sv
// link_partner: behavioural far-side port for the reset and detect machine
// assumes bench commands are one-cycle pulses changed at the falling edge
`default_nettype none
module link_partner (
	input wire logic sys_clk, // shared clock
	input wire logic rst, // power-on reset
	input wire logic wake_go, // pulse: leave hibernate
	input wire logic [3:0] wake_mask, // pairs that leave hibernate
	input wire logic lr_go, // pulse: signal a line reset
	input wire logic [7:0] lr_len, // line reset length in cycles
	input wire logic ts2_go, // pulse: send ts2 with reset bit
	input wire logic tmw_go, // pulse: write the test mode register
	input wire logic line_reset_issue, // line reset from the port
	output logic [3:0] rx_hib_exit, // hibernate exit per pair
	output logic line_reset_seen, // line reset on the link
	output logic line_reset_busy, // line reset in progress
	output logic ts2_reset_rx, // ts2 reset bit seen
	output logic test_mode_write // test mode register write
);
	timeunit 1ns;
	timeprecision 1ps;
	int busy_left;
	// defined levels before the first edge
	initial begin
		rx_hib_exit = 4'h0;
		line_reset_seen = 1'b0;
		line_reset_busy = 1'b0;
		ts2_reset_rx = 1'b0;
		test_mode_write = 1'b0;
		busy_left = 0;
	end
	// commands read on the rising edge, never while the bench changes them
	always @(posedge sys_clk) begin
		line_reset_seen <= 1'b0;
		ts2_reset_rx <= ts2_go;
		test_mode_write <= tmw_go;
		if (rst) begin
			rx_hib_exit <= 4'h0;
			line_reset_busy <= 1'b0;
			busy_left = 0;
		end else if (lr_go || line_reset_issue) begin
			// a line reset puts the partner back into hibernate as well
			rx_hib_exit <= 4'h0;
			line_reset_seen <= 1'b1;
			line_reset_busy <= 1'b1;
			busy_left = (lr_len == 8'h00) ? 16 : int'(lr_len);
		end else begin
			if (wake_go) begin
				rx_hib_exit <= wake_mask;
			end
			if (busy_left > 0) begin
				busy_left--;
			end
			line_reset_busy <= (busy_left > 0);
		end
	end
endmodule : link_partner
`default_nettype wire

// ### verification/testbench.sv
// testbench: random and corner runs of the reset and receiver-detect machine
// assumes link_pkg, timer_if, cycle_timer and link_partner are compiled first
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, is_downstream = 1'b0;
	logic direct_disable = 1'b0, direct_enable = 1'b0, hot_reset_req = 1'b0;
	logic hot_reset_done = 1'b0, hot_reset_fail = 1'b0, config_update = 1'b0;
	logic [15:0] activate_cycles = 16'h0010, rx_min_activate_capability = 16'h0010;
	logic [15:0] reset_hold_cycles = 16'h0010, line_to_local_reset_delay = 16'h0004;
	logic wake_go = 1'b0, lr_go = 1'b0, ts2_go = 1'b0, tmw_go = 1'b0;
	logic [3:0] wake_mask = 4'h0;
	logic [7:0] lr_len = 8'h10;
	logic [3:0] rx_hib_exit, phy_local_reset, tx_wake, rx_wake;
	logic line_reset_seen, line_reset_busy, ts2_reset_rx, test_mode_write, neg_lvl;
	logic line_reset_issue, ts2_reset_tx, config_update_transition, clear_error_count, in_u0;
	logic [8:0] state_out;
	int errors = 0, cmp_count = 0, n_u0 = 0, n_clr = 0, n_cut = 0, n_lri = 0;
	always #2.5 sys_clk = ~sys_clk;
	link_reset_and_detect_fsm dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.is_downstream(is_downstream), .direct_disable(direct_disable),
		.direct_enable(direct_enable), .line_reset_seen(line_reset_seen),
		.line_reset_busy(line_reset_busy), .rx_hib_exit(rx_hib_exit),
		.ts2_reset_rx(ts2_reset_rx), .hot_reset_req(hot_reset_req),
		.hot_reset_done(hot_reset_done), .hot_reset_fail(hot_reset_fail),
		.test_mode_write(test_mode_write), .config_update(config_update),
		.activate_cycles(activate_cycles),
		.rx_min_activate_capability(rx_min_activate_capability),
		.reset_hold_cycles(reset_hold_cycles),
		.line_to_local_reset_delay(line_to_local_reset_delay),
		.phy_local_reset(phy_local_reset), .tx_wake(tx_wake), .rx_wake(rx_wake),
		.lane_pair_zero_negative_line_level(neg_lvl), .line_reset_issue(line_reset_issue),
		.ts2_reset_tx(ts2_reset_tx), .config_update_transition(config_update_transition),
		.clear_error_count(clear_error_count), .state_out(state_out), .in_u0(in_u0));
	link_partner partner (.sys_clk(sys_clk), .rst(rst), .wake_go(wake_go),
		.wake_mask(wake_mask), .lr_go(lr_go), .lr_len(lr_len), .ts2_go(ts2_go),
		.tmw_go(tmw_go), .line_reset_issue(line_reset_issue), .rx_hib_exit(rx_hib_exit),
		.line_reset_seen(line_reset_seen), .line_reset_busy(line_reset_busy),
		.ts2_reset_rx(ts2_reset_rx), .test_mode_write(test_mode_write));
	// ****************************************************
	// pulse counters and helpers
	// ****************************************************
	// one-cycle outputs are counted at the edge that shows them
	always @(posedge sys_clk) begin
		if (in_u0 === 1'b1) n_u0++;
		if (clear_error_count === 1'b1) n_clr++;
		if (config_update_transition === 1'b1) n_cut++;
		if (line_reset_issue === 1'b1) n_lri++;
	end
	task automatic check_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check_vec
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask : pulse
	// bounded wait; a state that never comes shows up as a mismatch
	task automatic wait_state(input link_pkg::link_state_e s, input int lim, output int n);
		n = 0;
		while (state_out !== s && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		check_vec("state", 16'(s), 16'(state_out));
	endtask : wait_state
	task automatic bring_up(input logic ds);
		int n;
		rst = 1'b1;
		is_downstream = ds;
		repeat (16) @(negedge sys_clk);
		check_vec("phy reset", 16'h000f, 16'(phy_local_reset));
		check_vec("state", 16'(link_pkg::st_disabled), 16'(state_out));
		rst = 1'b0;
		if (ds) begin
			repeat (20) @(negedge sys_clk);
			check_vec("state", 16'(link_pkg::st_disabled), 16'(state_out));
			pulse(direct_enable);
		end
		wait_state(link_pkg::st_det_active, 12, n);
		check_vec("phy reset", 16'h0000, 16'(phy_local_reset));
	endtask : bring_up
	task automatic to_polling();
		int n, c;
		c = n_cut;
		pulse(config_update);
		// enable held low longer than any activate wait: nothing may move
		@(negedge sys_clk);
		ce = 1'b0;
		repeat (48) @(negedge sys_clk);
		check_vec("frozen state", 16'(link_pkg::st_cfg_wait), 16'(state_out));
		ce = 1'b1;
		wait_state(link_pkg::st_polling, 40 + int'(rx_min_activate_capability), n);
		check_vec("cut wait", 16'h1, 16'(n >= rx_min_activate_capability));
		check_vec("cut pulses", 16'(c + 1), 16'(n_cut));
	endtask : to_polling
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		int n, t, u;
		void'($urandom(77));
		// upstream: hibernate until any pair wakes, then test mode
		bring_up(1'b0);
		repeat (30) @(negedge sys_clk);
		check_vec("state", 16'(link_pkg::st_det_active), 16'(state_out));
		check_vec("wake", 16'h0000, 16'({tx_wake, rx_wake}));
		wait_state(link_pkg::st_det_active, 1, n);
		wake_mask = 4'h1 << ($urandom % 4);
		pulse(wake_go);
		wait_state(link_pkg::st_low_speed, 12, n);
		check_vec("tx wake", 16'h000f, 16'(tx_wake));
		pulse(tmw_go);
		wait_state(link_pkg::st_phy_test, 10, n);
		// upstream hot reset from the partner leaves the error count alone
		bring_up(1'b0);
		wake_mask = 4'hf;
		pulse(wake_go);
		wait_state(link_pkg::st_low_speed, 12, n);
		to_polling();
		t = n_clr;
		u = n_u0;
		pulse(ts2_go);
		wait_state(link_pkg::st_hot_reset, 10, n);
		pulse(hot_reset_done);
		repeat (6) @(negedge sys_clk);
		check_vec("u0 pulses", 16'(u + 1), 16'(n_u0));
		check_vec("error clears", 16'(t), 16'(n_clr));
		// an upstream hot reset failure falls back to detect, never to warm reset
		pulse(ts2_go);
		wait_state(link_pkg::st_hot_reset, 10, n);
		pulse(hot_reset_fail);
		wait_state(link_pkg::st_det_active, 10, n);
		check_vec("negative level", 16'h0, 16'(neg_lvl));
		// downstream rounds with random timing; the last ends in a failed hot reset
		for (int r = 0; r < 3; r++) begin
			activate_cycles = 16'(8 + $urandom % 40);
			rx_min_activate_capability = 16'(8 + $urandom % 40);
			reset_hold_cycles = 16'(8 + $urandom % 40);
			line_to_local_reset_delay = 16'(2 + $urandom % 10);
			lr_len = 8'(12 + $urandom % 20);
			bring_up(1'b1);
			check_vec("tx rx wake", 16'h00f0, 16'({tx_wake, rx_wake}));
			wake_mask = 4'hf;
			pulse(wake_go);
			wait_state(link_pkg::st_low_speed, 40 + int'(activate_cycles), n);
			check_vec("activate wait", 16'h1, 16'(n >= activate_cycles));
			check_vec("rx wake", 16'h000f, 16'(rx_wake));
			to_polling();
			t = n_clr;
			u = n_u0;
			hot_reset_req = 1'b1;
			wait_state(link_pkg::st_hot_reset, 10, n);
			check_vec("ts2 send", 16'h1, 16'(ts2_reset_tx));
			hot_reset_req = 1'b0;
			if (r == 2) begin
				t = n_lri;
				pulse(hot_reset_fail);
				n = 0;
				while (neg_lvl !== 1'b1 && n < 10) begin
					@(negedge sys_clk);
					n++;
				end
				check_vec("negative level", 16'h1, 16'(neg_lvl));
				// the drive must outlast any short span before the line reset
				repeat (300) @(negedge sys_clk);
				check_vec("negative level", 16'h1, 16'(neg_lvl));
				check_vec("early line reset", 16'(t), 16'(n_lri));
			end else begin
				pulse(hot_reset_done);
				repeat (6) @(negedge sys_clk);
				check_vec("u0 pulses", 16'(u + 1), 16'(n_u0));
				check_vec("error clears", 16'(t + 1), 16'(n_clr));
				// line reset from the partner, local reset sequence, then disable
				bring_up(1'b1);
				pulse(lr_go);
				wait_state(link_pkg::st_det_reset, 10, n);
				n = 0;
				while (phy_local_reset !== 4'hf && n < 60 + int'(lr_len)) begin
					@(negedge sys_clk);
					n++;
				end
				check_vec("phy reset", 16'h000f, 16'(phy_local_reset));
				check_vec("busy at reset", 16'h0, 16'(line_reset_busy));
				n = 0;
				while (phy_local_reset === 4'hf && n < 60 + int'(reset_hold_cycles)) begin
					@(negedge sys_clk);
					n++;
				end
				check_vec("reset hold", 16'h1, 16'(n >= reset_hold_cycles));
				wait_state(link_pkg::st_det_active, 10, n);
				pulse(direct_disable);
				wait_state(link_pkg::st_disabled, 10, n);
				check_vec("phy reset", 16'h000f, 16'(phy_local_reset));
			end
		end
		conclude();
	end
	// watchdog well beyond the fewer than 1500 cycles the run needs
	initial begin
		#100000;
		errors++;
		conclude();
	end
endmodule : testbench
`default_nettype wire
